// ==== design/nvm_paging_pkg.sv ====
package nvm_paging_pkg;
  // data-space addresses and cpu_addr[7:6] region codes
  localparam logic [7:0] ADDR_WINDOW_BASE  = 8'h00_C9;
  localparam logic [7:0] ADDR_PAGE_SELECT  = 8'h00_E8;
  localparam logic [7:0] ADDR_NVM_CONTROL  = 8'h00_EA;
  localparam logic [1:0] REGION_PAGED      = 2'h0;
  localparam logic [1:0] REGION_WINDOW     = 2'h1;

  // nvm_control layout and reset value
  localparam logic [7:0] NVM_CONTROL_RESET = 8'h00_00;
  localparam int         STANDBY_BIT       = 6;
  localparam int         GO_BIT            = 3;
  localparam int         ARM_BIT           = 2;
  localparam int         BUSY_BIT          = 1;
  localparam int         WE_BIT            = 0;

  // page_select codes
  localparam logic [7:0] PAGE_NONE         = 8'h00_00;
  localparam logic [7:0] PAGE_NVM0         = 8'h00_01;
  localparam logic [7:0] PAGE_NVM1         = 8'h00_02;
  localparam logic [7:0] PAGE_RAM2         = 8'h00_10;

  // physical page index inside the page memory
  localparam logic [1:0] IDX_RAM2          = 2'h0;
  localparam logic [1:0] IDX_NVM0          = 2'h1;
  localparam logic [1:0] IDX_NVM1          = 2'h2;
  localparam int         MEM_DEPTH         = 192;
  localparam int         MEM_AW            = 8;
  localparam int         ROW_BYTES         = 8;

  // programming time
  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         PROG_TIME_NS      = 5000;
  localparam int         PROG_CYCLES       = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int         PROG_CNT_W        = 10;

  typedef enum logic [1:0] {PROG_IDLE, PROG_WAIT, PROG_COMMIT} prog_state_t;
endpackage

// ==== design/page_mem.sv ====
`timescale 1ns/100ps
module page_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 192,
  parameter int AW    = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] cells [DEPTH];

  // array has no reset: it models retained cells
  always_ff @(posedge clk_sys) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      cells[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= (int'(rd_addr) < DEPTH) ? cells[rd_addr] : '0;
    end
  end
endmodule // page_mem

// ==== design/data_space_paging_eeprom_ctl.sv ====
`timescale 1ns/100ps
module data_space_paging_eeprom_ctl (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic        stop_exec,
  input  wire logic [7:0]  pm_rdata,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_rvalid,
  output logic      [11:0] pm_addr,
  output logic             pm_rd,
  output logic             nvm_program_active,
  output logic             nvm_standby
);
  logic [5:0]  window_base_bits;
  logic [7:0]  page_select;
  logic        nvm_write_enable, next_write_enable;
  logic        row_mode_arm, next_arm;
  logic        row_program_go, next_go;
  logic        next_busy, next_standby;
  nvm_paging_pkg::prog_state_t state, next_state;
  logic [nvm_paging_pkg::PROG_CNT_W-1:0] prog_cnt, next_prog_cnt;
  logic [4:0]  row_addr, next_row_addr;
  logic        row_valid, next_row_valid;
  logic [7:0]  row_mask, next_row_mask;
  logic [7:0]  row_data [8];
  logic [7:0]  next_row_data [8];
  logic [2:0]  byte_idx, next_byte_idx;
  logic        page_ok, page_is_nvm, nvm_usable;
  logic [1:0]  page_idx;
  logic        in_paged, in_window, ram_wr;
  logic        mem_we, mem_re;
  logic [7:0]  mem_wr_addr, mem_wr_data, mem_rd_data;
  logic        mem_pend, next_mem_pend, mem_blank, next_mem_blank;
  logic        win1, next_win1, win2, next_win2;
  logic [7:0]  next_rdata;
  logic        next_rvalid, next_pm_rd;
  logic [11:0] next_pm_addr;

  assign in_paged  = cpu_addr[7:6] == nvm_paging_pkg::REGION_PAGED;
  assign in_window = cpu_addr[7:6] == nvm_paging_pkg::REGION_WINDOW;

  always_comb begin
    page_ok     = 1'b1;
    page_is_nvm = 1'b0;
    page_idx    = nvm_paging_pkg::IDX_RAM2;
    unique case (page_select)
      nvm_paging_pkg::PAGE_RAM2: page_idx = nvm_paging_pkg::IDX_RAM2;
      nvm_paging_pkg::PAGE_NVM0: begin
        page_idx    = nvm_paging_pkg::IDX_NVM0;
        page_is_nvm = 1'b1;
      end
      nvm_paging_pkg::PAGE_NVM1: begin
        page_idx    = nvm_paging_pkg::IDX_NVM1;
        page_is_nvm = 1'b1;
      end
      default: page_ok = 1'b0;
    endcase
  end

  // nvm usable only out of standby and idle
  assign nvm_usable = page_ok && page_is_nvm && !nvm_standby && !nvm_program_active;
  assign ram_wr     = cpu_wr && in_paged && page_ok && !page_is_nvm;

  // write-only registers have no reset by design; software must load them first
  // window base keeps only six bits
  always_ff @(posedge clk_sys) begin
    if (cpu_wr && cpu_addr == nvm_paging_pkg::ADDR_WINDOW_BASE) begin
      window_base_bits <= cpu_wdata[5:0];
    end
    if (cpu_wr && cpu_addr == nvm_paging_pkg::ADDR_PAGE_SELECT) begin
      page_select <= cpu_wdata;
    end
  end

  // control, row latches and programming sequencer
  always_comb begin
    next_write_enable = nvm_write_enable;
    next_arm          = row_mode_arm;
    next_go           = row_program_go;
    next_busy         = nvm_program_active;
    next_standby      = nvm_standby;
    next_state        = state;
    next_prog_cnt     = prog_cnt;
    next_row_addr     = row_addr;
    next_row_valid    = row_valid;
    next_row_mask     = row_mask;
    next_row_data     = row_data;
    next_byte_idx     = byte_idx;
    mem_we            = 1'b0;
    mem_wr_addr       = {page_idx, cpu_addr[5:0]};
    mem_wr_data       = cpu_wdata;
    if (cpu_wr && cpu_addr == nvm_paging_pkg::ADDR_NVM_CONTROL) begin
      if (!nvm_program_active) begin
        next_standby      = cpu_wdata[nvm_paging_pkg::STANDBY_BIT];
        next_write_enable = cpu_wdata[nvm_paging_pkg::WE_BIT];
        next_arm          = cpu_wdata[nvm_paging_pkg::ARM_BIT];
        if (cpu_wdata[nvm_paging_pkg::ARM_BIT] != row_mode_arm) begin
          next_row_mask  = '0;
          next_row_valid = 1'b0;
        end
        if (cpu_wdata[nvm_paging_pkg::GO_BIT] && cpu_wdata[nvm_paging_pkg::WE_BIT]
            && cpu_wdata[nvm_paging_pkg::ARM_BIT] && row_mode_arm) begin
          next_go       = 1'b1;
          next_busy     = 1'b1;
          next_state    = nvm_paging_pkg::PROG_WAIT;
          next_prog_cnt = '0;
        end
      end
    end else if (cpu_wr && in_paged) begin
      // page offset from low six bits
      if (ram_wr) begin
        mem_we = 1'b1;
      end else if (nvm_usable && nvm_write_enable) begin
        if (row_mode_arm) begin
          if (!row_valid || row_addr == {page_idx, cpu_addr[5:3]}) begin
            next_row_valid                = 1'b1;
            next_row_addr                 = {page_idx, cpu_addr[5:3]};
            next_row_mask[cpu_addr[2:0]]  = 1'b1;
            next_row_data[cpu_addr[2:0]]  = cpu_wdata;
          end
        end else begin
          next_row_addr                 = {page_idx, cpu_addr[5:3]};
          next_row_mask                 = '0;
          next_row_mask[cpu_addr[2:0]]  = 1'b1;
          next_row_data[cpu_addr[2:0]]  = cpu_wdata;
          next_busy                     = 1'b1;
          next_state                    = nvm_paging_pkg::PROG_WAIT;
          next_prog_cnt                 = '0;
        end
      end
    end
    unique case (state)
      nvm_paging_pkg::PROG_IDLE: ;
      nvm_paging_pkg::PROG_WAIT: begin
        next_prog_cnt = prog_cnt + 1'b1;
        if (prog_cnt == nvm_paging_pkg::PROG_CNT_W'(nvm_paging_pkg::PROG_CYCLES - 1)) begin
          next_state    = nvm_paging_pkg::PROG_COMMIT;
          next_byte_idx = '0;
        end
      end
      nvm_paging_pkg::PROG_COMMIT: begin
        // ram writes own the port; commit slips a cycle rather than drop a byte
        if (!ram_wr) begin
          mem_we        = row_mask[byte_idx];
          mem_wr_addr   = {row_addr, byte_idx};
          mem_wr_data   = row_data[byte_idx];
          next_byte_idx = byte_idx + 1'b1;
          if (byte_idx == 3'(nvm_paging_pkg::ROW_BYTES - 1)) begin
            // busy drops only after the last byte
            next_busy      = 1'b0;
            next_go        = 1'b0;
            next_arm       = 1'b0;
            next_row_mask  = '0;
            next_row_valid = 1'b0;
            next_state     = nvm_paging_pkg::PROG_IDLE;
          end
        end
      end
    endcase
    if (stop_exec) begin
      next_standby = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nvm_write_enable   <= nvm_paging_pkg::NVM_CONTROL_RESET[nvm_paging_pkg::WE_BIT];
      row_mode_arm       <= nvm_paging_pkg::NVM_CONTROL_RESET[nvm_paging_pkg::ARM_BIT];
      row_program_go     <= nvm_paging_pkg::NVM_CONTROL_RESET[nvm_paging_pkg::GO_BIT];
      nvm_program_active <= nvm_paging_pkg::NVM_CONTROL_RESET[nvm_paging_pkg::BUSY_BIT];
      nvm_standby        <= nvm_paging_pkg::NVM_CONTROL_RESET[nvm_paging_pkg::STANDBY_BIT];
      state              <= nvm_paging_pkg::PROG_IDLE;
      prog_cnt           <= '0;
      row_addr           <= '0;
      row_valid          <= 1'b0;
      row_mask           <= '0;
      row_data           <= '{default: '0};
      byte_idx           <= '0;
    end else begin
      nvm_write_enable   <= next_write_enable;
      row_mode_arm       <= next_arm;
      row_program_go     <= next_go;
      nvm_program_active <= next_busy;
      nvm_standby        <= next_standby;
      state              <= next_state;
      prog_cnt           <= next_prog_cnt;
      row_addr           <= next_row_addr;
      row_valid          <= next_row_valid;
      row_mask           <= next_row_mask;
      row_data           <= next_row_data;
      byte_idx           <= next_byte_idx;
    end
  end

  page_mem #(
    .WIDTH (8),
    .DEPTH (nvm_paging_pkg::MEM_DEPTH),
    .AW    (nvm_paging_pkg::MEM_AW)
  ) u_page_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wr_en   (mem_we),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_en   (mem_re),
    .rd_addr ({page_idx, cpu_addr[5:0]}),
    .rd_data (mem_rd_data)
  );

  // read path: page reads 2 cycles, window 3, control 1
  always_comb begin
    mem_re         = 1'b0;
    next_mem_pend  = 1'b0;
    next_mem_blank = 1'b0;
    next_win1      = 1'b0;
    next_win2      = win1;
    next_pm_rd     = 1'b0;
    next_pm_addr   = pm_addr;
    next_rvalid    = 1'b0;
    next_rdata     = cpu_rdata;
    if (cpu_rd && in_paged) begin
      mem_re         = 1'b1;
      next_mem_pend  = 1'b1;
      // same latency for ram and nvm
      next_mem_blank = !page_ok || (page_is_nvm && !nvm_usable);
    end else if (cpu_rd && in_window) begin
      next_pm_addr = {window_base_bits, cpu_addr[5:0]};
      next_pm_rd   = 1'b1;
      next_win1    = 1'b1;
    end else if (cpu_rd && cpu_addr == nvm_paging_pkg::ADDR_NVM_CONTROL) begin
      // busy always readable, write-only bits read zero
      next_rvalid                           = 1'b1;
      next_rdata                            = '0;
      next_rdata[nvm_paging_pkg::BUSY_BIT]  = nvm_program_active;
    end
    if (mem_pend) begin
      next_rvalid = 1'b1;
      next_rdata  = mem_blank ? '0 : mem_rd_data;
    end else if (win2) begin
      next_rvalid = 1'b1;
      next_rdata  = pm_rdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_pend   <= 1'b0;
      mem_blank  <= 1'b0;
      win1       <= 1'b0;
      win2       <= 1'b0;
      pm_rd      <= 1'b0;
      pm_addr    <= '0;
      cpu_rvalid <= 1'b0;
      cpu_rdata  <= '0;
    end else begin
      mem_pend   <= next_mem_pend;
      mem_blank  <= next_mem_blank;
      win1       <= next_win1;
      win2       <= next_win2;
      pm_rd      <= next_pm_rd;
      pm_addr    <= next_pm_addr;
      cpu_rvalid <= next_rvalid;
      cpu_rdata  <= next_rdata;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_busy_start;
    $rose(nvm_program_active);
  endsequence
  sequence s_busy_hold;
    nvm_program_active [*8];
  endsequence

  property p_window_addr;
    cpu_rd && in_window |=> pm_rd && pm_addr == {$past(window_base_bits), $past(cpu_addr[5:0])};
  endproperty
  a_window_addr: assert property (p_window_addr) else $error("window address wrong");

  property p_window_no_readback;
    cpu_rd && cpu_addr == nvm_paging_pkg::ADDR_WINDOW_BASE |=> !cpu_rvalid;
  endproperty
  a_window_no_readback: assert property (p_window_no_readback) else $error("base read answered");

  property p_page_latency;
    cpu_rd && in_paged |-> ##2 cpu_rvalid;
  endproperty
  a_page_latency: assert property (p_page_latency) else $error("paged read latency");

  property p_ram_page_write;
    cpu_wr && in_paged && page_select == nvm_paging_pkg::PAGE_RAM2
      |-> mem_we && mem_wr_addr == {nvm_paging_pkg::IDX_RAM2, cpu_addr[5:0]};
  endproperty
  a_ram_page_write: assert property (p_ram_page_write) else $error("ram page missed");

  property p_page_stable;
    !(cpu_wr && cpu_addr == nvm_paging_pkg::ADDR_PAGE_SELECT) |=> $stable(page_select);
  endproperty
  a_page_stable: assert property (p_page_stable) else $error("page_select moved");

  property p_busy_hold;
    s_busy_start |-> s_busy_hold;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

  property p_ctl_ignored_busy;
    nvm_program_active && state != nvm_paging_pkg::PROG_COMMIT && !stop_exec
      && cpu_wr && cpu_addr == nvm_paging_pkg::ADDR_NVM_CONTROL
      |=> $stable(nvm_standby) && $stable(nvm_write_enable) && $stable(row_mode_arm);
  endproperty
  a_ctl_ignored_busy: assert property (p_ctl_ignored_busy) else $error("ctl write taken");

  property p_commit_needs_we;
    state == nvm_paging_pkg::PROG_COMMIT && mem_we && !ram_wr |-> nvm_write_enable;
  endproperty
  a_commit_needs_we: assert property (p_commit_needs_we) else $error("program w/o enable");

  property p_stop_standby;
    stop_exec |=> nvm_standby;
  endproperty
  a_stop_standby: assert property (p_stop_standby) else $error("stop ignored");

  property p_arm_self_clear;
    $fell(nvm_program_active) && row_program_go == 1'b0 |-> !row_mode_arm;
  endproperty
  a_arm_self_clear: assert property (p_arm_self_clear) else $error("arm kept");

  property p_go_needs_arm;
    $rose(row_program_go) |-> $past(row_mode_arm) && nvm_write_enable && nvm_program_active;
  endproperty
  a_go_needs_arm: assert property (p_go_needs_arm) else $error("go without arm");

  property p_row_lock;
    cpu_wr && in_paged && row_mode_arm && row_valid && nvm_usable
      && row_addr != {page_idx, cpu_addr[5:3]} |=> $stable(row_mask);
  endproperty
  a_row_lock: assert property (p_row_lock) else $error("other row latched");

  property p_arm_clears;
    cpu_wr && cpu_addr == nvm_paging_pkg::ADDR_NVM_CONTROL && !nvm_program_active
      && cpu_wdata[nvm_paging_pkg::ARM_BIT] && !row_mode_arm |=> row_mask == 8'h00_00;
  endproperty
  a_arm_clears: assert property (p_arm_clears) else $error("latches kept");
endmodule // data_space_paging_eeprom_ctl

// ==== test/prog_mem_model.sv ====
`timescale 1ns/100ps
module prog_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        pm_rd,
  input  wire logic [11:0] pm_addr,
  output logic      [7:0]  pm_rdata
);
  // sync array: data one cycle after the request, a different pattern otherwise
  always @(posedge clk_sys) begin
    if (pm_rd === 1'h1) begin
      pm_rdata <= pm_addr[7:0] ^ {pm_addr[11:8], ~pm_addr[11:8]};
    end else begin
      pm_rdata <= ~pm_addr[7:0];
    end
  end
endmodule // prog_mem_model

// ==== test/data_space_paging_eeprom_ctl_test.sv ====
`timescale 1ns/100ps
module data_space_paging_eeprom_ctl_test;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  cpu_addr;
  logic [7:0]  cpu_wdata;
  logic        cpu_wr;
  logic        cpu_rd;
  logic        stop_exec;
  logic [7:0]  pm_rdata;
  logic [7:0]  cpu_rdata;
  logic        cpu_rvalid;
  logic [11:0] pm_addr;
  logic        pm_rd;
  logic        nvm_program_active;
  logic        nvm_standby;
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  rdat;
  logic        got;
  logic        pm_seen;
  logic [7:0]  wbase [2] = '{8'h00_E8, 8'h00_3F};
  logic [7:0]  waddr [2] = '{8'h00_59, 8'h00_7F};
  logic [11:0] wexp  [2] = '{12'hA19, 12'hFFF};

  data_space_paging_eeprom_ctl u_data_space_paging_eeprom_ctl (
    .clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .stop_exec(stop_exec), .pm_rdata(pm_rdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .nvm_program_active(nvm_program_active), .nvm_standby(nvm_standby));

  prog_mem_model u_prog_mem_model (
    .clk_sys(clk_sys), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // whole run is about 2200 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] pm_val(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], ~a[11:8]};
  endfunction

  // only the main thread writes, never an interrupt context
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'h1;
    @(negedge clk_sys);
    cpu_wr = 1'h0;
  endtask

  // waits out the longest answer so reads never overlap
  task automatic rd(input logic [7:0] a);
    int n;
    got = 1'h0;
    pm_seen = 1'h0;
    rdat = 8'h00_00;
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_rd = 1'h1;
    @(negedge clk_sys);
    cpu_rd = 1'h0;
    for (n = 0; n < 5; n++) begin
      if (pm_rd === 1'h1) begin
        pm_seen = 1'h1;
      end
      if (cpu_rvalid === 1'h1 && got === 1'h0) begin
        got = 1'h1;
        rdat = cpu_rdata;
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(what, {7'h00, got}, 8'h00_01);
    chk(what, rdat, exp);
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 700 && nvm_program_active !== 1'h0; n++) @(negedge clk_sys);
  endtask

  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    int t0;
    wr(a, d);
    t0 = cyc;
    chk("busy_set", {7'h00, nvm_program_active}, 8'h00_01);
    rdc(8'h00_EA, 8'h00_02, "busy_read");
    rdc(a, 8'h00_00, "nvm_while_busy");
    wr(8'h00_EA, 8'h00_40);
    wait_idle();
    // wait cycles plus one commit cycle per row byte
    chk("busy_len", 8'(cyc - t0 == nvm_paging_pkg::PROG_CYCLES
        + nvm_paging_pkg::ROW_BYTES), 8'h00_01);
    chk("ctl_locked", {7'h00, nvm_standby}, 8'h00_00);
  endtask

  initial begin
    int i;
    rst = 1'h1;
    cpu_addr = 8'h00_00;
    cpu_wdata = 8'h00_00;
    cpu_wr = 1'h0;
    cpu_rd = 1'h0;
    stop_exec = 1'h0;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    chk("standby_rst", {7'h00, nvm_standby}, 8'h00_00);
    chk("busy_rst", {7'h00, nvm_program_active}, 8'h00_00);
    rdc(8'h00_EA, 8'h00_00, "ctl_rst");
    done("reset");

    for (i = 0; i < 2; i++) begin
      wr(8'h00_C9, wbase[i]);
      rdc(waddr[i], pm_val(wexp[i]), "window_data");
      chk("window_req", {7'h00, pm_seen}, 8'h00_01);
      chk("window_hi", pm_addr[11:4], wexp[i][11:4]);
      chk("window_lo", {4'h0, pm_addr[3:0]}, {4'h0, wexp[i][3:0]});
    end
    rd(8'h00_C9);
    chk("base_noread", {7'h00, got}, 8'h00_00);
    rd(8'h00_E8);
    chk("page_noread", {7'h00, got}, 8'h00_00);
    done("window");

    wr(8'h00_E8, 8'h00_10);
    wr(8'h00_05, 8'h00_A5);
    wr(8'h00_3F, 8'h00_5A);
    rdc(8'h00_05, 8'h00_A5, "ram2_lo");
    chk("paged_no_pm", {7'h00, pm_seen}, 8'h00_00);
    rdc(8'h00_3F, 8'h00_5A, "ram2_hi");
    wr(8'h00_E8, 8'h00_00);
    rdc(8'h00_05, 8'h00_00, "no_page");
    wr(8'h00_E8, 8'h00_08);
    rdc(8'h00_05, 8'h00_00, "reserved_page");
    done("pages");

    wr(8'h00_E8, 8'h00_01);
    // control bits 4-5 always written clear
    wr(8'h00_EA, 8'h00_01);
    prog(8'h00_12, 8'h00_3C);
    prog(8'h00_18, 8'h00_66);
    wr(8'h00_E8, 8'h00_02);
    prog(8'h00_12, 8'h00_C3);
    rdc(8'h00_12, 8'h00_C3, "nvm1");
    wr(8'h00_E8, 8'h00_01);
    rdc(8'h00_12, 8'h00_3C, "nvm0");
    done("byte_write");

    wr(8'h00_EA, 8'h00_00);
    wr(8'h00_12, 8'h00_99);
    chk("no_enable", {7'h00, nvm_program_active}, 8'h00_00);
    rdc(8'h00_12, 8'h00_3C, "no_enable_data");
    wr(8'h00_EA, 8'h00_09);
    chk("go_unarmed", {7'h00, nvm_program_active}, 8'h00_00);
    done("refusals");

    // page held, no nvm reads while armed
    wr(8'h00_EA, 8'h00_05);
    wr(8'h00_10, 8'h00_11);
    wr(8'h00_11, 8'h00_22);
    wr(8'h00_18, 8'h00_55);
    wr(8'h00_EA, 8'h00_0D);
    chk("row_busy", {7'h00, nvm_program_active}, 8'h00_01);
    wait_idle();
    rdc(8'h00_10, 8'h00_11, "row_b0");
    rdc(8'h00_11, 8'h00_22, "row_b1");
    rdc(8'h00_12, 8'h00_3C, "row_untouched");
    rdc(8'h00_18, 8'h00_66, "other_row");
    wr(8'h00_EA, 8'h00_0D);
    chk("arm_cleared", {7'h00, nvm_program_active}, 8'h00_00);
    wr(8'h00_EA, 8'h00_01);
    done("row_write");

    wr(8'h00_EA, 8'h00_41);
    chk("standby_set", {7'h00, nvm_standby}, 8'h00_01);
    rdc(8'h00_12, 8'h00_00, "standby_read");
    wr(8'h00_EA, 8'h00_01);
    chk("standby_clr", {7'h00, nvm_standby}, 8'h00_00);
    @(negedge clk_sys);
    stop_exec = 1'h1;
    @(negedge clk_sys);
    stop_exec = 1'h0;
    chk("stop_standby", {7'h00, nvm_standby}, 8'h00_01);
    rdc(8'h00_12, 8'h00_00, "stop_read");
    done("standby");

    // page_select survives a reset in mid-run
    wr(8'h00_E8, 8'h00_10);
    @(negedge clk_sys);
    rst = 1'h1;
    @(negedge clk_sys);
    rst = 1'h0;
    chk("standby_rst2", {7'h00, nvm_standby}, 8'h00_00);
    rdc(8'h00_05, 8'h00_A5, "page_kept");
    done("second_reset");
    end_of_test();
  end
endmodule // data_space_paging_eeprom_ctl_test
